/* logic/flash_defs.vh */
// Constants for the erase and deep power-down command sequencer.
// Assumes a 250 MHz core clock and a host that drives the serial clock.
// How it works
// [RULE_01] Host erases 32KB block with 52H plus three address bytes, any inner address.
// [RULE_02] Host erases 64KB block with D8H plus three address bytes, any inner address.
// [RULE_03] Write-enable must set the latch first; erase only runs while it is set.
// [RULE_04] Chip select rises right after the last address bit, else no block erase.
// [RULE_05] Valid block erase starts a timed cycle; busy flag 1 during, 0 after.
// [RULE_06] Write enable latch is cleared during every timed erase cycle.
// [RULE_07] Block erase refused when the target block is protected.
// [RULE_08] Chip erase is 60H or C7H alone, chip select rising after eighth bit.
// [RULE_09] Valid chip erase runs a timed array erase with busy flag held high.
// [RULE_10] Chip erase only with low protect bits all 0/CMP 0 or all 1/CMP 1.
// [RULE_11] Deep sleep request is B9H alone, chip select rising after eighth bit.
// [RULE_12] After a valid sleep request, wait the entry delay before sleeping.
// [RULE_13] Asleep, only wake, enable reset and reset are heard; each wakes. Code: enable reset only arms the reset and does not wake.
// [RULE_14] Sleep request during a running cycle is rejected; cycle goes on.
// [RULE_15] Plain deselect with no cycle gives standby, never deep sleep.
// [RULE_16] Power-up always lands in standby.
// [RULE_17] Wake command can also shift the identifier out on the serial output.
// [RULE_18] After wake, no command is accepted until the wake delay passes. Code: enable reset still arms the reset during the delay.
// [RULE_19] Erase and sleep entry durations are parameters for simulation.
`ifndef FLASH_DEFS_VH
`define FLASH_DEFS_VH

// ****************************************************************
// Opcodes
// ****************************************************************
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_READ_STATUS    8'h05
`define OP_ERASE_32K      8'h52
`define OP_ERASE_64K      8'hD8
`define OP_CHIP_ERASE_A   8'h60
`define OP_CHIP_ERASE_B   8'hC7
`define OP_DEEP_SLEEP     8'hB9
`define OP_WAKE_ID        8'hAB
`define OP_RESET_ENABLE   8'h66
`define OP_RESET          8'h99

// ****************************************************************
// Frame lengths in serial clocks
// ****************************************************************
`define BITS_OPCODE       6'h08
`define BITS_ADDRESSED    6'h20
`define BITS_SATURATE     6'h3F

// ****************************************************************
// Array geometry and protection
// ****************************************************************
`define BLK64_LSB         16
`define BLK32_LSB         15
`define BLK_COUNT         5'h10
`define PROT_ALL_CODE     3'h5
`define PROT_LOW_ALL1     3'h7

// ****************************************************************
// Timing, core clock in MHz and durations in microseconds
// ****************************************************************
`define MCLK_MHZ          250
`define BLOCK_ERASE_US    150000
`define ARRAY_ERASE_US    2000000
`define SLEEP_ENTRY_US    3
`define WAKE_DELAY_US     3

// ****************************************************************
// Sequencer states
// ****************************************************************
`define ST_IDLE           3'h0
`define ST_BUSY           3'h1
`define ST_SLEEP_ENTRY    3'h2
`define ST_SLEEP          3'h3
`define ST_WAKING         3'h4

// ****************************************************************
// Erase kinds and identity
// ****************************************************************
`define KIND_32K          2'h1
`define KIND_64K          2'h2
`define KIND_CHIP         2'h3
`define DEVICE_ID_DEF     8'h5A

`endif

/* logic/pin_sync.v */
// Two-stage synchroniser for one pin, with edge detection after it.
// Assumes the pin toggles no faster than a few core clocks.
`timescale 1ns/1ns
module pin_sync (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_n_i,
    // Pin and result
    input  wire pin_i,
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edges are taken only after the second stage
    assign level_o = sync_q;
    assign rise_o  = sync_q & ~prev_q;
    assign fall_o  = ~sync_q & prev_q;
endmodule // pin_sync

/* logic/flash_erase_sleep.v */
// Erase and deep power-down command sequencer behind the serial pins.
// Assumes the serial clock and chip select come straight from the host pins.
`timescale 1ns/1ns
`include "flash_defs.vh"
module flash_erase_sleep #(
    parameter [31:0] BLOCK_ERASE_CYC = `BLOCK_ERASE_US * `MCLK_MHZ, // [RULE_19]
    parameter [31:0] ARRAY_ERASE_CYC = `ARRAY_ERASE_US * `MCLK_MHZ,
    parameter [31:0] SLEEP_ENTRY_CYC = `SLEEP_ENTRY_US * `MCLK_MHZ,
    parameter [31:0] WAKE_DELAY_CYC  = `WAKE_DELAY_US * `MCLK_MHZ,
    parameter [7:0]  DEVICE_ID       = `DEVICE_ID_DEF // Arbitrary value
) (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        rstn_i,
    // Serial link pins
    input  wire        sclk_i,
    input  wire        cs_n_i,
    input  wire        si_i,
    output reg         so_o,
    output reg         so_en_o,
    // Protection settings
    input  wire [4:0]  protect_bits_i,
    input  wire        protect_complement_i,
    // Status
    output reg         write_in_progress_o,
    output reg         write_enable_latch_o,
    output reg         deep_sleep_o,
    output reg  [23:0] erase_addr_o,
    output reg  [1:0]  erase_kind_o
);
    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    reg rst_meta_q;
    reg rst_n_q;

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    wire sclk_rise;
    wire sclk_fall;
    wire cs_rise;
    wire cs_fall;
    wire si;

    pin_sync u_sclk (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_q),
        .pin_i   (sclk_i),
        .level_o (),
        .rise_o  (sclk_rise),
        .fall_o  (sclk_fall)
    );

    pin_sync u_cs (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_q),
        .pin_i   (~cs_n_i),
        .level_o (),
        .rise_o  (cs_fall),
        .fall_o  (cs_rise)
    );

    pin_sync u_si (
        .clk_i   (mclk_i),
        .rst_n_i (rst_n_q),
        .pin_i   (si_i),
        .level_o (si),
        .rise_o  (),
        .fall_o  ()
    );

    // ****************************************************************
    // Protection decode
    // ****************************************************************
    // Simple top/bottom scheme in 64KB blocks; 32KB blocks inherit their parent
    function blk_protected;
        input [3:0] blk;
        input [4:0] bp;
        input       cmp;
        reg   [4:0] span;
        reg         hit;
        begin
            span = 5'h00;
            hit  = 1'b0;
            if (bp[2:0] >= `PROT_ALL_CODE)
                span = `BLK_COUNT;
            else if (bp[2:0] != 3'h0)
                span = 5'h01 << (bp[2:0] - 3'h1);
            if (bp[3])
                hit = ({1'b0, blk} < span);
            else
                hit = ({1'b0, blk} >= (`BLK_COUNT - span));
            blk_protected = hit ^ cmp;
        end
    endfunction

    wire chip_ok = ((protect_bits_i[2:0] == 3'h0) && !protect_complement_i) ||
                   ((protect_bits_i[2:0] == `PROT_LOW_ALL1) && protect_complement_i); // [RULE_10]

    // ****************************************************************
    // Serial shift-in
    // ****************************************************************
    reg        sel_q;
    reg [5:0]  bits_q;
    reg [23:0] sh_q;
    reg [7:0]  op_q;
    reg [23:0] addr_q;
    reg        out_status_q;
    reg        out_id_q;
    reg [2:0]  oidx_q;
    reg [2:0]  st_q;
    reg        wel_q;
    reg        rst_armed_q;
    reg [31:0] tmr_q;

    wire [23:0] sh_next = {sh_q[22:0], si};
    wire [7:0]  status  = {1'b0, protect_bits_i, wel_q, (st_q == `ST_BUSY)};
    wire [7:0]  out_byte = out_status_q ? status : DEVICE_ID;
    wire        asleep  = (st_q == `ST_SLEEP) || (st_q == `ST_SLEEP_ENTRY);

    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sel_q        <= 1'b0;
            bits_q       <= 6'h00;
            sh_q         <= 24'h000000;
            op_q         <= 8'h00;
            addr_q       <= 24'h000000;
            out_status_q <= 1'b0;
            out_id_q     <= 1'b0;
            oidx_q       <= 3'h0;
            so_o         <= 1'b0;
            so_en_o      <= 1'b0;
        end else begin
            if (cs_fall) begin
                sel_q        <= 1'b1;
                bits_q       <= 6'h00;
                out_status_q <= 1'b0;
                out_id_q     <= 1'b0;
                oidx_q       <= 3'h0;
            end else if (cs_rise) begin
                sel_q        <= 1'b0;
                out_status_q <= 1'b0;
                out_id_q     <= 1'b0;
                so_en_o      <= 1'b0;
            end else if (sel_q && sclk_rise) begin
                sh_q <= sh_next;
                if (bits_q != `BITS_SATURATE)
                    bits_q <= bits_q + 6'h01;
                if (bits_q == `BITS_OPCODE - 6'h01) begin
                    op_q <= sh_next[7:0];
                    // Status reads stay live in every state except sleep entry, deep sleep and the wake delay
                    if (sh_next[7:0] == `OP_READ_STATUS && !asleep && st_q != `ST_WAKING)
                        out_status_q <= 1'b1;
                end
                if (bits_q == `BITS_ADDRESSED - 6'h01) begin
                    addr_q <= sh_next;
                    if (op_q == `OP_WAKE_ID && st_q != `ST_BUSY && st_q != `ST_WAKING)
                        out_id_q <= 1'b1; // [RULE_17]
                end
            end else if (sel_q && sclk_fall && (out_status_q || out_id_q)) begin
                so_o    <= out_byte[~oidx_q];
                so_en_o <= 1'b1;
                oidx_q  <= oidx_q + 3'h1;
            end
        end
    end

    // ****************************************************************
    // Command execution and self-timed cycles
    // ****************************************************************
    wire one_byte  = (bits_q == `BITS_OPCODE);
    wire addressed = (bits_q == `BITS_ADDRESSED);
    wire blk_op    = (op_q == `OP_ERASE_32K) || (op_q == `OP_ERASE_64K);
    wire chip_op   = (op_q == `OP_CHIP_ERASE_A) || (op_q == `OP_CHIP_ERASE_B);
    wire blk_prot  = blk_protected(addr_q[19:`BLK64_LSB], protect_bits_i, protect_complement_i);
    wire frame_end = cs_rise && sel_q && (bits_q >= `BITS_OPCODE);

    always @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q                 <= `ST_IDLE; // [RULE_16]
            wel_q                <= 1'b0;
            rst_armed_q          <= 1'b0;
            tmr_q                <= 32'h00000000;
            write_in_progress_o  <= 1'b0;
            write_enable_latch_o <= 1'b0;
            deep_sleep_o         <= 1'b0;
            erase_addr_o         <= 24'h000000;
            erase_kind_o         <= 2'h0;
        end else begin
            if (frame_end)
                rst_armed_q <= one_byte && (op_q == `OP_RESET_ENABLE);
            case (st_q)
                `ST_IDLE: begin
                    // Deselect alone leaves the sequencer idle
                    if (frame_end) begin // [RULE_15]
                        if (one_byte && op_q == `OP_WRITE_ENABLE)
                            wel_q <= 1'b1;
                        else if (one_byte && op_q == `OP_WRITE_DISABLE)
                            wel_q <= 1'b0;
                        else if (one_byte && op_q == `OP_RESET && rst_armed_q)
                            wel_q <= 1'b0;
                        else if (one_byte && op_q == `OP_DEEP_SLEEP) begin // [RULE_11]
                            st_q  <= `ST_SLEEP_ENTRY; // [RULE_12]
                            tmr_q <= SLEEP_ENTRY_CYC - 32'h1;
                        end else if (one_byte && chip_op && wel_q && chip_ok) begin // [RULE_08] [RULE_03] [RULE_10]
                            st_q         <= `ST_BUSY; // [RULE_09]
                            tmr_q        <= ARRAY_ERASE_CYC - 32'h1;
                            wel_q        <= 1'b0; // [RULE_06]
                            erase_addr_o <= 24'h000000;
                            erase_kind_o <= `KIND_CHIP;
                        end else if (addressed && blk_op && wel_q && !blk_prot) begin // [RULE_04] [RULE_03] [RULE_07]
                            st_q         <= `ST_BUSY; // [RULE_05]
                            tmr_q        <= BLOCK_ERASE_CYC - 32'h1;
                            wel_q        <= 1'b0; // [RULE_06]
                            if (op_q == `OP_ERASE_32K) begin
                                // Any inner address picks the enclosing block
                                erase_addr_o <= {addr_q[23:`BLK32_LSB], 15'h0000}; // [RULE_01]
                                erase_kind_o <= `KIND_32K;
                            end else begin
                                erase_addr_o <= {addr_q[23:`BLK64_LSB], 16'h0000}; // [RULE_02]
                                erase_kind_o <= `KIND_64K;
                            end
                        end
                    end
                end
                `ST_BUSY: begin
                    // Sleep and every other command except status read and reset enable, which still arms, are ignored until done
                    if (tmr_q == 32'h0) // [RULE_14]
                        st_q <= `ST_IDLE;
                    else
                        tmr_q <= tmr_q - 32'h1;
                end
                `ST_SLEEP_ENTRY, `ST_SLEEP: begin
                    if (st_q == `ST_SLEEP_ENTRY && tmr_q == 32'h0)
                        st_q <= `ST_SLEEP;
                    else if (st_q == `ST_SLEEP_ENTRY)
                        tmr_q <= tmr_q - 32'h1;
                    if (frame_end && op_q == `OP_WAKE_ID) begin // [RULE_13]
                        st_q  <= `ST_WAKING; // [RULE_18]
                        tmr_q <= WAKE_DELAY_CYC - 32'h1;
                    end else if (frame_end && one_byte && op_q == `OP_RESET && rst_armed_q) begin
                        st_q  <= `ST_IDLE; // [RULE_13]
                        wel_q <= 1'b0;
                    end
                end
                `ST_WAKING: begin
                    // Commands other than reset enable, which still arms, are dropped inside the wake delay
                    if (tmr_q == 32'h0) // [RULE_18]
                        st_q <= `ST_IDLE;
                    else
                        tmr_q <= tmr_q - 32'h1;
                end
                default: begin
                    st_q <= `ST_IDLE;
                end
            endcase
            write_in_progress_o  <= (st_q == `ST_BUSY); // [RULE_05]
            write_enable_latch_o <= wel_q;
            deep_sleep_o         <= (st_q == `ST_SLEEP);
        end
    end
endmodule // flash_erase_sleep

/* tb/flash_erase_sleep_asserts.sv */
// Checker for the erase and deep sleep sequencer ports.
// Assumes a bind onto flash_erase_sleep and stable protect inputs.
`timescale 1ns/1ns
module flash_erase_sleep_chk #(
    parameter [31:0] BLOCK_ERASE_CYC = 32'h0000_0190,
    parameter [31:0] ARRAY_ERASE_CYC = 32'h0000_0258,
    parameter [31:0] SLEEP_ENTRY_CYC = 32'h0000_0014
) (
    // Clock, reset and link
    input logic        mclk_i,
    input logic        rstn_i,
    input logic        cs_n_i,
    input logic [4:0]  protect_bits_i,
    input logic        protect_complement_i,
    // Status
    input logic        so_en_o,
    input logic        write_in_progress_o,
    input logic        write_enable_latch_o,
    input logic        deep_sleep_o,
    input logic [23:0] erase_addr_o,
    input logic [1:0]  erase_kind_o
);
    // ****************************************************************
    // Cycle counters, too long for a repetition
    // ****************************************************************
    logic [31:0] busy_q;
    logic [31:0] desel_q;
    logic [31:0] cycle_len;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_q <= 32'h0;
            desel_q <= 32'h0;
        end else begin
            busy_q <= write_in_progress_o ? busy_q + 32'h1 : 32'h0;
            desel_q <= cs_n_i ? desel_q + 32'h1 : 32'h0;
        end
    end
    assign cycle_len = (erase_kind_o == 2'h3) ? ARRAY_ERASE_CYC : BLOCK_ERASE_CYC;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    sequence erase_start;
        $rose(write_in_progress_o);
    endsequence
    sequence quiet_link;
        cs_n_i [*6];
    endsequence
    latch_handover_a: assert property (erase_start |->
        !write_enable_latch_o && $past(write_enable_latch_o))
        else $error("erase start without latch handover");
    start_on_deselect_a: assert property (erase_start |-> cs_n_i && $past(cs_n_i, 2))
        else $error("erase start while selected");
    erase_length_a: assert property ($fell(write_in_progress_o) |->
        busy_q >= cycle_len && busy_q <= cycle_len + 32'h1)
        else $error("erase busy time wrong");
    chip_guard_a: assert property ((erase_start and (erase_kind_o == 2'h3)) |->
        (protect_bits_i[2:0] == 3'h0 && !protect_complement_i) ||
        (protect_bits_i[2:0] == 3'h7 && protect_complement_i))
        else $error("chip erase under protection");
    block_align_a: assert property (erase_start |->
        (erase_kind_o != 2'h1 || erase_addr_o[14:0] == 15'h0) &&
        (erase_kind_o != 2'h2 || erase_addr_o[15:0] == 16'h0) &&
        (erase_kind_o != 2'h3 || erase_addr_o == 24'h0))
        else $error("erase base not aligned");
    // Record is written with the state, one cycle ahead of the busy flag
    record_moves_a: assert property ($changed(erase_kind_o) || $changed(erase_addr_o) |=>
        $rose(write_in_progress_o))
        else $error("erase record moved without a cycle");
    sleep_not_busy_a: assert property (!(deep_sleep_o && write_in_progress_o))
        else $error("asleep during a cycle");
    sleep_delay_a: assert property ($rose(deep_sleep_o) |-> desel_q >= SLEEP_ENTRY_CYC)
        else $error("sleep entered too early");
    wake_deselect_a: assert property ($fell(deep_sleep_o) |-> cs_n_i)
        else $error("woke while selected");
    output_released_a: assert property (quiet_link |-> !so_en_o)
        else $error("serial output driven while deselected");
endmodule // flash_erase_sleep_chk

/* tb/flash_host.sv */
// Host side of the serial link: frames commands, collects the reply.
// Assumes one caller at a time; mode 0, 80 ns serial period.
`timescale 1ns/1ns
module flash_host (
    // Link pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o,
    input  logic so_i
);
    // Clock stands still between frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    task automatic send(input logic [39:0] d, input int n, output logic [39:0] rx);
        int i;
        rx = 40'h0;
        cs_n_o = 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            si_o = d[i];
            #40;
            sclk_o = 1'b1;
            rx = {rx[38:0], so_i};
            #40;
            sclk_o = 1'b0;
        end
        #40;
        cs_n_o = 1'b1;
        si_o = ~si_o; // No pull: never leave the last bit standing
        #40;
    endtask
endmodule // flash_host

/* tb/tb_flash_erase_sleep.sv */
// Testbench for the erase and deep sleep sequencer.
// Assumes flash_host as link master and the checker bound below.
`timescale 1ns/1ns
module tb_flash_erase_sleep;
    // ****************************************************************
    // Settings and signals
    // ****************************************************************
    localparam [31:0] WAKE_CYC = 32'h0000_0014;
    localparam [7:0]  ID_VAL   = 8'h3C; // Arbitrary value
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [4:0]  prot = 5'h00;
    logic        cmp = 1'b0;
    logic        sclk, cs_n, si;
    wire         so, so_en, write_in_progress, write_enable_latch, deep;
    wire  [23:0] addr;
    wire  [1:0]  kind;
    logic [39:0] rx;
    int          errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    flash_host u_flash_host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
    flash_erase_sleep #(.BLOCK_ERASE_CYC(32'h190), .ARRAY_ERASE_CYC(32'h258), .SLEEP_ENTRY_CYC(32'h14),
        .WAKE_DELAY_CYC(WAKE_CYC), .DEVICE_ID(ID_VAL)) u_flash_erase_sleep (.mclk_i(mclk), .rstn_i(rstn),
        .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_en_o(so_en), .protect_bits_i(prot),
        .protect_complement_i(cmp), .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch),
        .deep_sleep_o(deep), .erase_addr_o(addr), .erase_kind_o(kind));
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            report_and_stop();
        end
    end
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [39:0] d, input int n);
        u_flash_host.send(d, n, rx);
    endtask
    task automatic wait_wip(input logic v);
        for (int k = 0; k < 1000 && write_in_progress !== v; k++)
            step(1);
        check("busy", {23'h0, v}, {23'h0, write_in_progress});
    endtask
    task automatic set_prot(input logic [4:0] b, input logic c);
        step(1);
        prot = b;
        cmp = c;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_erase(input logic we, input logic [39:0] cmd, input int n, input logic ok,
                           input logic [1:0] k, input logic [23:0] base);
        if (we)
            xfer(40'h06, 8);
        xfer(cmd, n);
        step(4);
        if (ok) begin
            wait_wip(1'b1);
            check("latch", 24'h0, {23'h0, write_enable_latch});
            check("kind", {22'h0, k}, {22'h0, kind});
            check("base", base, addr);
            wait_wip(1'b0);
        end else begin
            check("busy", 24'h0, {23'h0, write_in_progress});
        end
        $display("erase test done, frame %h", cmd);
    endtask
    task automatic t_sleep(input int m);
        xfer(40'hB9, 9);
        step(40);
        check("sleep", 24'h0, {23'h0, deep});
        xfer(40'hB9, 8);
        check("sleep", 24'h0, {23'h0, deep});
        step(40);
        check("sleep", 24'h1, {23'h0, deep});
        xfer(40'h06, 8);
        step(4);
        check("latch", 24'h0, {23'h0, write_enable_latch});
        if (m == 0) begin
            xfer(40'hAB, 8);
        end else begin
            xfer(40'h66, 8);
            xfer(40'h99, 8);
        end
        step(4);
        check("sleep", 24'h0, {23'h0, deep});
        step(WAKE_CYC + 8);
        $display("sleep test done, wake kind %0d", m);
    endtask
    task automatic t_busy_sleep;
        xfer(40'h06, 8);
        xfer({8'hD8, 24'h020000}, 32);
        xfer(40'hB9, 8);
        check("busy", 24'h1, {23'h0, write_in_progress});
        wait_wip(1'b0);
        step(40);
        check("sleep", 24'h0, {23'h0, deep});
        $display("sleep during erase test done");
    endtask
    task automatic t_id;
        // Second pass reads the identifier while waking from deep sleep
        for (int m = 0; m < 2; m++) begin
            if (m == 1) begin
                xfer(40'hB9, 8);
                step(40);
            end
            xfer({8'hAB, 32'h0}, 40);
            check("ident", {16'h0, ID_VAL}, {16'h0, rx[7:0]});
            check("sleep", 24'h0, {23'h0, deep});
            step(WAKE_CYC + 8);
        end
        $display("ident test done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        step(12);
        rstn = 1'b1;
        step(6);
        check("status", 24'h0, {17'h0, write_in_progress, write_enable_latch, deep, so_en, kind, 1'b0});
        t_erase(1, {8'h52, 24'h0ABCDE}, 32, 1, 2'h1, 24'h0A8000);
        t_erase(1, {8'hD8, 24'h03FFFF}, 32, 1, 2'h2, 24'h030000);
        t_erase(0, {8'hD8, 24'h050000}, 32, 0, 2'h0, 24'h0);
        t_erase(1, {8'hD8, 24'h050000}, 31, 0, 2'h0, 24'h0);
        t_erase(1, 40'hC7C7, 16, 0, 2'h0, 24'h0);
        t_erase(1, 40'h60, 8, 1, 2'h3, 24'h0);
        set_prot(5'h01, 1'b0);
        t_erase(1, {8'hD8, 24'h0F1234}, 32, 0, 2'h0, 24'h0);
        t_erase(1, {8'h52, 24'h0F8000}, 32, 0, 2'h0, 24'h0);
        t_erase(1, 40'hC7, 8, 0, 2'h0, 24'h0);
        t_erase(1, {8'h52, 24'h0E8001}, 32, 1, 2'h1, 24'h0E8000);
        set_prot(5'h00, 1'b1);
        t_erase(1, 40'h60, 8, 0, 2'h0, 24'h0);
        set_prot(5'h07, 1'b1);
        t_erase(1, 40'hC7, 8, 1, 2'h3, 24'h0);
        set_prot(5'h00, 1'b0);
        t_sleep(0);
        t_sleep(1);
        t_busy_sleep;
        t_id;
        report_and_stop();
    end
endmodule // tb_flash_erase_sleep
bind flash_erase_sleep flash_erase_sleep_chk #(.BLOCK_ERASE_CYC(BLOCK_ERASE_CYC),
    .ARRAY_ERASE_CYC(ARRAY_ERASE_CYC), .SLEEP_ENTRY_CYC(SLEEP_ENTRY_CYC)) u_chk (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .cs_n_i(cs_n_i), .protect_bits_i(protect_bits_i), .protect_complement_i(protect_complement_i),
    .so_en_o(so_en_o), .write_in_progress_o(write_in_progress_o), .write_enable_latch_o(write_enable_latch_o),
    .deep_sleep_o(deep_sleep_o), .erase_addr_o(erase_addr_o), .erase_kind_o(erase_kind_o));
